// file: hdl/cmac_core.v
`timescale 1ns/1ps
`include "cmac_defs.vh"


module cmac_core (
  // System
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Transmit FIFO, show-ahead head byte
  input  wire        tx_valid,
  input  wire [7:0]  tx_data,
  input  wire        tx_last,
  output reg         tx_pop,
  output reg         tx_rewind,
  output reg         tx_done,
  output reg         tx_abort,
  // Receive FIFO
  output reg         rx_valid,
  output reg  [7:0]  rx_data,
  output reg         rx_last,
  output reg         rx_bad,
  // PHY
  input  wire        tx_line_clock,
  output reg  [3:0]  txd,
  output reg         tx_en,
  input  wire        col,
  input  wire        crs,
  input  wire        rx_line_clock,
  input  wire        rx_dv,
  input  wire        rx_er,
  input  wire [3:0]  rxd
);

  localparam T_IDLE = 3'h0;
  localparam T_PRE  = 3'h1;
  localparam T_DATA = 3'h2;
  localparam T_PAD  = 3'h3;
  localparam T_FCS  = 3'h4;
  localparam T_JAM  = 3'h5;
  localparam T_BACK = 3'h6;
  localparam T_IFG  = 3'h7;

  function [9:0] ticks;
    input [9:0] bits;
    input       ser;
    begin
      ticks = ser ? bits : {2'h0, bits[9:2]};
    end
  endfunction

  function [9:0] bo_mask;
    input [4:0] n;
    reg   [4:0] k;
    begin
      k = (n > `CMAC_BO_LIMIT) ? `CMAC_BO_LIMIT : n;
      bo_mask = (10'h001 << k) - 10'h001;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and line clock edges

  wire [9:0] s_pins;
  reg        txc_d;
  reg        rxc_d;

  cmac_sync #(.W(10)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({tx_line_clock, rx_line_clock, col, crs, rx_dv, rx_er, rxd}),
    .q     (s_pins)
  );

  wire       s_txc   = s_pins[9];
  wire       s_rxc   = s_pins[8];
  wire       col_s   = s_pins[7];
  wire       crs_s   = s_pins[6];
  wire       dv_s    = s_pins[5];
  wire       er_s    = s_pins[4];
  wire [3:0] rxd_s   = s_pins[3:0];
  // Edges found at pclk rate, so the line clock must stay well below pclk / 2
  wire       tx_tick = s_txc & ~txc_d;
  wire       rx_tick = s_rxc & ~rxc_d;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_d <= 1'b0;
      rxc_d <= 1'b0;
    end else begin
      txc_d <= s_txc;
      rxc_d <= s_rxc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [3:0]  ctrl;
  reg  [31:0] addr_lo;
  reg  [15:0] addr_hi;
  reg  [4:0]  sticky;
  reg  [4:0]  att;
  reg         rx_act;
  reg  [2:0]  ts;
  reg         set_lost;
  reg         set_excol;
  reg         set_code;
  reg         set_crc;
  reg         set_drop;
  reg  [31:0] rd_mux;

  wire serial  = ctrl[`CMAC_CTRL_SERIAL];
  wire fdx     = ctrl[`CMAC_CTRL_FDX];
  wire tx_busy = (ts != T_IDLE) && (ts <= T_JAM);
  wire setup   = psel & ~penable;
  wire wr_acc  = psel & penable & pready & pwrite;

  always @* begin
    case (paddr)
      `CMAC_A_CTRL:    rd_mux = {28'h0000000, ctrl};
      `CMAC_A_STAT:    rd_mux = {15'h0000, att, 2'h0, rx_act, tx_busy, 3'h0, sticky};
      `CMAC_A_ADDR_LO: rd_mux = addr_lo;
      `CMAC_A_ADDR_HI: rd_mux = {16'h0000, addr_hi};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      ctrl    <= `CMAC_CTRL_RST;
      addr_lo <= 32'h00000000;
      addr_hi <= 16'h0000;
      sticky  <= 5'h00;
    end else begin
      pready  <= setup;
      pslverr <= setup && (paddr != `CMAC_A_CTRL) && (paddr != `CMAC_A_STAT) &&
                 (paddr != `CMAC_A_ADDR_LO) && (paddr != `CMAC_A_ADDR_HI);
      if (setup) begin
        prdata <= rd_mux;
      end
      if (wr_acc && (paddr == `CMAC_A_CTRL)) begin
        ctrl <= pwdata[3:0];
      end
      if (wr_acc && (paddr == `CMAC_A_ADDR_LO)) begin
        addr_lo <= pwdata;
      end
      if (wr_acc && (paddr == `CMAC_A_ADDR_HI)) begin
        addr_hi <= pwdata[15:0];
      end
      // A hardware event in the clearing cycle survives the clear
      sticky <= (sticky & ~((wr_acc && (paddr == `CMAC_A_STAT)) ? pwdata[4:0] : 5'h00)) |
                {set_drop, set_crc, set_code, set_excol, set_lost};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit

  reg  [7:0]  cur;
  reg  [3:0]  ubits;
  reg  [3:0]  bcnt;
  reg  [5:0]  dcnt;
  reg         last_b;
  reg  [31:0] tcrc;
  reg  [31:0] fcs;
  reg  [9:0]  cnt;
  reg  [9:0]  slots;
  reg  [9:0]  ccnt;
  reg         cs_seen;
  reg  [15:0] lfsr;
  wire [3:0]  step     = serial ? 4'h1 : 4'h4;
  wire        from_q   = (ts == T_DATA) ? !last_b : (ts == T_PRE);
  wire [7:0]  nbyte    = from_q ? tx_data : 8'h00;
  wire        tx_line  = (ts != T_IDLE) && (ts <= T_FCS);
  wire [4:0]  att_n    = att + 5'h01;
  wire [31:0] tcrc_nx;

  cmac_crc u_tcrc (
    .crc_in  (tcrc),
    .data    (nbyte),
    .crc_out (tcrc_nx)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts <= T_IDLE;
      txd <= 4'h0;
      tx_en <= 1'b0;
      cur <= 8'h00;
      ubits <= 4'h0;
      bcnt <= 4'h0;
      dcnt <= 6'h00;
      last_b <= 1'b0;
      tcrc <= `CMAC_CRC_INIT;
      fcs <= 32'h00000000;
      cnt <= 10'h000;
      slots <= 10'h000;
      ccnt <= 10'h000;
      cs_seen <= 1'b0;
      att <= 5'h00;
      lfsr <= `CMAC_LFSR_SEED;
      tx_pop <= 1'b0;
      tx_rewind <= 1'b0;
      tx_done <= 1'b0;
      tx_abort <= 1'b0;
      set_lost <= 1'b0;
      set_excol <= 1'b0;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      tx_pop <= 1'b0;
      tx_rewind <= 1'b0;
      tx_done <= 1'b0;
      tx_abort <= 1'b0;
      set_lost <= 1'b0;
      set_excol <= 1'b0;
      if (tx_tick) begin
        if (ts == T_IDLE) begin
          if (tx_valid && (fdx || !crs_s)) begin
            cur <= `CMAC_PRE_BYTE;
            ubits <= 4'h8;
            bcnt <= 4'h0;
            dcnt <= 6'h00;
            tcrc <= `CMAC_CRC_INIT;
            ccnt <= 10'h000;
            cs_seen <= 1'b0;
            ts <= T_PRE;
          end
        end else if (tx_line && !fdx && col_s) begin
          ts <= T_JAM;
          cnt <= ticks(`CMAC_JAM_BITS, serial);
        end else if (tx_line) begin
          // Unit and enable change together on one line clock rise
          txd <= serial ? {3'h0, cur[0]} : cur[3:0];
          tx_en <= 1'b1;
          cur <= serial ? {1'b0, cur[7:1]} : {4'h0, cur[7:4]};
          ubits <= ubits - step;
          if (crs_s) begin
            cs_seen <= 1'b1;
          end
          if (ccnt < ticks(`CMAC_SLOT_BITS, serial)) begin
            ccnt <= ccnt + 10'h001;
          end
          if (!fdx && !cs_seen && !crs_s &&
              (ccnt == ticks(`CMAC_SLOT_BITS, serial) - 10'h001)) begin
            set_lost <= 1'b1;
          end
          if (ubits == step) begin
            ubits <= 4'h8;
            if (from_q || (ts == T_PAD) || ((ts == T_DATA) && (dcnt < `CMAC_MIN_DATA))) begin
              if ((ts == T_PRE) && (bcnt < `CMAC_PRE_LAST)) begin
                cur <= `CMAC_PRE_BYTE;
                bcnt <= bcnt + 4'h1;
              end else if ((ts == T_PRE) && (bcnt == `CMAC_PRE_LAST)) begin
                cur <= `CMAC_SFD_BYTE;
                bcnt <= bcnt + 4'h1;
              end else if ((ts != T_PAD) || (dcnt < `CMAC_MIN_DATA)) begin
                cur <= nbyte;
                tcrc <= tcrc_nx;
                last_b <= tx_last;
                tx_pop <= from_q;
                ts <= from_q ? T_DATA : T_PAD;
                if (dcnt < `CMAC_MIN_DATA) begin
                  dcnt <= dcnt + 6'h01;
                end
              end else begin
                cur <= ~tcrc[7:0];
                fcs <= {8'h00, ~tcrc[31:8]};
                bcnt <= 4'h0;
                ts <= T_FCS;
              end
            end else if (ts != T_FCS) begin
              cur <= ~tcrc[7:0];
              fcs <= {8'h00, ~tcrc[31:8]};
              bcnt <= 4'h0;
              ts <= T_FCS;
            end else if (bcnt == 4'h3) begin
              ts <= T_IFG;
              cnt <= ticks(`CMAC_IFG_BITS, serial);
              att <= 5'h00;
              tx_done <= 1'b1;
            end else begin
              cur <= fcs[7:0];
              fcs <= {8'h00, fcs[31:8]};
              bcnt <= bcnt + 4'h1;
            end
          end
        end else if (ts == T_JAM) begin
          txd <= serial ? {3'h0, cnt[0]} : `CMAC_JAM_NIB;
          tx_en <= 1'b1;
          cnt <= cnt - 10'h001;
          if (cnt == 10'h001) begin
            if (att_n == `CMAC_MAX_ATT) begin
              set_excol <= 1'b1;
              tx_abort <= 1'b1;
              att <= 5'h00;
              ts <= T_IFG;
              cnt <= ticks(`CMAC_IFG_BITS, serial);
            end else begin
              att <= att_n;
              slots <= lfsr[9:0] & bo_mask(att_n);
              tx_rewind <= 1'b1;
              ts <= T_BACK;
              cnt <= ticks(`CMAC_SLOT_BITS, serial);
            end
          end
        end else begin
          txd <= 4'h0;
          tx_en <= 1'b0;
          cnt <= cnt - 10'h001;
          if (ts == T_BACK) begin
            if (slots == 10'h000) begin
              ts <= T_IFG;
              cnt <= ticks(`CMAC_IFG_BITS, serial);
            end else if (cnt == 10'h001) begin
              slots <= slots - 10'h001;
              cnt <= ticks(`CMAC_SLOT_BITS, serial);
            end
          end else if (cnt == 10'h001) begin
            ts <= T_IDLE;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive

  reg  [7:0]  dl [0:5];
  reg  [7:0]  asm_b;
  reg  [3:0]  apos;
  reg  [3:0]  prev_u;
  reg  [15:0] rcnt;
  reg         sfd;
  reg         acc;
  reg         rerr;
  reg  [1:0]  rflush;
  reg  [31:0] rcrc;
  wire        take   = serial ? crs_s : dv_s;
  wire [7:0]  asm_nx = serial ? {rxd_s[0], asm_b[7:1]} : {rxd_s, asm_b[7:4]};
  wire [47:0] da     = {asm_nx, dl[0], dl[1], dl[2], dl[3], dl[4]};
  wire        hit    = ctrl[`CMAC_CTRL_PROM] | (ctrl[`CMAC_CTRL_MCAST] & dl[4][0]) |
                       (da == {addr_hi, addr_lo});
  wire [31:0] rcrc_nx;
  integer     i;

  cmac_crc u_rcrc (
    .crc_in  (rcrc),
    .data    (asm_nx),
    .crc_out (rcrc_nx)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 6; i = i + 1) begin
        dl[i] <= 8'h00;
      end
      rx_act <= 1'b0;
      asm_b <= 8'h00;
      apos <= 4'h0;
      prev_u <= 4'h0;
      rcnt <= 16'h0000;
      sfd <= 1'b0;
      acc <= 1'b0;
      rerr <= 1'b0;
      rflush <= 2'h0;
      rcrc <= `CMAC_CRC_INIT;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_last <= 1'b0;
      rx_bad <= 1'b0;
      set_code <= 1'b0;
      set_crc <= 1'b0;
      set_drop <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      set_code <= 1'b0;
      set_crc <= 1'b0;
      set_drop <= 1'b0;
      if (!rx_act) begin
        if (rflush != 2'h0) begin
          // Drain the two data bytes still held ahead of the FCS
          rx_valid <= 1'b1;
          rx_data <= (rflush == 2'h2) ? dl[5] : dl[4];
          rx_last <= (rflush == 2'h1);
          rx_bad <= (rflush == 2'h1) && (rerr || (rcrc != `CMAC_CRC_RESID));
          rflush <= rflush - 2'h1;
        end else if (crs_s && (fdx || !tx_busy)) begin
          rx_act <= 1'b1;
          sfd <= 1'b0;
          apos <= 4'h0;
          prev_u <= 4'h0;
          rcnt <= 16'h0000;
          acc <= 1'b0;
          rerr <= 1'b0;
          rcrc <= `CMAC_CRC_INIT;
        end
      end else if (!crs_s) begin
        rx_act <= 1'b0;
        if (sfd && acc && (rcnt >= `CMAC_RX_MIN)) begin
          rflush <= 2'h2;
          set_code <= rerr;
          set_crc <= (rcrc != `CMAC_CRC_RESID);
        end
      end else if (rx_tick && take) begin
        if (!serial && er_s) begin
          rerr <= 1'b1;
        end
        if (!sfd) begin
          // Preamble may arrive shortened; only the delimiter pattern matters
          prev_u <= rxd_s;
          if (serial ? (prev_u[0] & rxd_s[0]) : ((prev_u == 4'h5) && (rxd_s == 4'hD))) begin
            sfd <= 1'b1;
          end
        end else begin
          asm_b <= asm_nx;
          apos <= apos + step;
          if ((apos + step) == 4'h8) begin
            apos <= 4'h0;
            rcrc <= rcrc_nx;
            for (i = 5; i > 0; i = i - 1) begin
              dl[i] <= dl[i-1];
            end
            dl[0] <= asm_nx;
            if (rcnt != 16'hFFFF) begin
              rcnt <= rcnt + 16'h0001;
            end
            if (rcnt == `CMAC_DA_LAST) begin
              acc <= hit;
              set_drop <= !hit;
            end
            if ((rcnt >= `CMAC_DA_BYTES) && acc) begin
              rx_valid <= 1'b1;
              rx_data <= dl[5];
              rx_bad <= 1'b0;
            end
          end
        end
      end
    end
  end

endmodule

// file: hdl/cmac_crc.v
`timescale 1ns/1ps
`include "cmac_defs.vh"

module cmac_crc (
  // Running value and byte
  input  wire [31:0] crc_in,
  input  wire [7:0]  data,
  output reg  [31:0] crc_out
);

  integer i;

  // Reflected form, least significant bit of each byte first as on the wire
  always @* begin
    crc_out = crc_in;
    for (i = 0; i < 8; i = i + 1) begin
      crc_out = (crc_out >> 1) ^ ((crc_out[0] ^ data[i]) ? `CMAC_CRC_POLY : 32'h00000000);
    end
  end

endmodule

// file: hdl/cmac_defs.vh
`ifndef CMAC_DEFS_VH
`define CMAC_DEFS_VH

// Register byte addresses
`define CMAC_A_CTRL      12'h000
`define CMAC_A_STAT      12'h004
`define CMAC_A_ADDR_LO   12'h008
`define CMAC_A_ADDR_HI   12'h00C

// Control fields
`define CMAC_CTRL_SERIAL 0
`define CMAC_CTRL_FDX    1
`define CMAC_CTRL_PROM   2
`define CMAC_CTRL_MCAST  3
`define CMAC_CTRL_RST    4'h0

// Status fields, sticky bits are write-one-to-clear
`define CMAC_ST_LOST     0
`define CMAC_ST_EXCOL    1
`define CMAC_ST_RXCODE   2
`define CMAC_ST_RXCRC    3
`define CMAC_ST_RXDROP   4
`define CMAC_ST_TXBUSY   8
`define CMAC_ST_RXACT    9
`define CMAC_ST_ATT_LSB  12

// Line timing in bit times
`define CMAC_SLOT_BITS   10'h200
`define CMAC_IFG_BITS    10'h060
`define CMAC_JAM_BITS    10'h020

// Frame layout, retry limits, CRC and backoff LFSR constants
`define CMAC_PRE_LAST    4'h6
`define CMAC_PRE_BYTE    8'h55
`define CMAC_SFD_BYTE    8'hD5
`define CMAC_JAM_NIB     4'h5
`define CMAC_MIN_DATA    6'h3C
`define CMAC_DA_LAST     16'h0005
`define CMAC_DA_BYTES    16'h0006
`define CMAC_RX_MIN      16'h000A
`define CMAC_MAX_ATT     5'h10
`define CMAC_BO_LIMIT    5'h0A
`define CMAC_CRC_INIT    32'hFFFFFFFF
`define CMAC_CRC_POLY    32'hEDB88320
`define CMAC_CRC_RESID   32'hDEBB20E3
`define CMAC_LFSR_SEED   16'hACE1

`endif

// file: hdl/cmac_sync.v
`timescale 1ns/1ps
`include "cmac_defs.vh"

module cmac_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// file: verification/cmac_core_bench.sv
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end

module cmac_core_bench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        tx_valid = 1'b0, tx_last = 1'b0, er, rbad;
  logic [7:0]  tx_data = 8'h00;
  wire  [31:0] prdata;
  wire  [7:0]  rx_data;
  wire  [3:0]  txd, rxd;
  wire         pready, pslverr, tx_pop, tx_rewind, tx_done, tx_abort, rx_valid, rx_last;
  wire         rx_bad, tx_line_clock, tx_en, col, crs, rx_line_clock, rx_dv, rx_er;
  wire  [3:0]  ev = {tx_en, tx_rewind, tx_done, rx_valid & rx_last};
  int          num_errors = 0, checks = 0, tptr = 0, rdone = 0;
  logic [7:0]  tq[$], rq[$], rf[$];
  logic [3:0]  exp_n[$], rn[$];

  always #25 pclk = ~pclk;

  cmac_core dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_pop(tx_pop), .tx_rewind(tx_rewind), .tx_done(tx_done), .tx_abort(tx_abort),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_bad(rx_bad),
    .tx_line_clock(tx_line_clock), .txd(txd), .tx_en(tx_en), .col(col), .crs(crs),
    .rx_line_clock(rx_line_clock), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd));
  cmac_phy_model phy_u (.tx_line_clock(tx_line_clock), .rx_line_clock(rx_line_clock),
    .txd(txd), .tx_en(tx_en), .col(col), .crs(crs), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd));

  ////////////////////////////////////////////////////////////////////////////////
  // Show-ahead FIFO holding one frame; rewind replays it without a refetch
  always @(posedge pclk) begin
    if (tx_pop) tptr = tptr + 1;
    if (tx_rewind) tptr = 0;
    if (tx_done || tx_abort) begin
      tq = {};
      tptr = 0;
    end
    tx_valid <= tptr < tq.size();
    tx_data <= (tptr < tq.size()) ? tq[tptr] : 8'h00;
    tx_last <= tptr + 1 == tq.size();
    if (rx_valid) rq.push_back(rx_data);
    if (rx_valid && rx_last) begin
      rdone++;
      rbad = rx_bad;
    end
  end

  task print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHECK("pready", 1'b1, pready)
    if (pready !== 1'b1) print_verdict();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                       input string s);
    apb(1'b0, a, 32'h0);
    `CHECK(s, x, rd & m)
  endtask

  task automatic wait_ev(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (ev[i] !== v) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin
        `CHECK("wait event", v, ev[i])
        print_verdict();
      end
    end
  endtask

  // Wire image: preamble, delimiter, bytes low nibble first, then inverted CRC
  task automatic to_nibs(input logic [7:0] b[$], output logic [3:0] n[$]);
    logic [31:0] c;
    logic [7:0]  v;
    c = 32'hFFFFFFFF;
    foreach (b[i]) begin
      c = c ^ {24'h0, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    end
    c = ~c;
    n = {};
    repeat (15) n.push_back(4'h5);
    n.push_back(4'hD);
    for (int i = 0; i < b.size() + 4; i++) begin
      v = (i < b.size()) ? b[i] : c[8*(i-b.size()) +: 8];
      n.push_back(v[3:0]);
      n.push_back(v[7:4]);
    end
  endtask

  task automatic load(input logic [7:0] d[$]);
    @(negedge pclk) tq = d;
    while (d.size() < 60) d.push_back(8'h00);
    to_nibs(d, exp_n);
  endtask

  task automatic tx_end(input int lim);
    wait_ev(1, 1'b1, lim);
    wait_ev(3, 1'b0, 200);
    repeat (20) @(posedge pclk);
    `CHECK("frame length", exp_n.size(), phy_u.last_f.size())
    foreach (exp_n[i]) `CHECK("tx nibble", exp_n[i], phy_u.last_f[i])
  endtask

  task automatic rx_check(input int frames, input logic bad);
    `CHECK("rx frames", frames, rdone)
    `CHECK("rx bad", bad, rbad)
    `CHECK("rx count", 60, rq.size())
    foreach (rf[i]) `CHECK("rx byte", rf[i], rq[i])
    rq = {};
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h000, 32'hF, 32'h0, "ctrl reset");
    rdchk(12'h004, 32'h1F, 32'h0, "stat reset");
    apb(1'b1, 12'h008, 32'h33221102);
    apb(1'b1, 12'h00C, 32'h00005544);
    rdchk(12'h00C, 32'hFFFFFFFF, 32'h00005544, "addr hi");
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    rdchk(12'h010, 32'hFFFFFFFF, 32'h0, "unmapped");
    `CHECK("slverr", 1'b1, er)
    load('{8'h12, 8'h34, 8'hA7, 8'h0F});
    tx_end(3000);
    rdchk(12'h004, 32'h1F, 32'h1, "lost carrier");
    apb(1'b1, 12'h004, 32'h1);
    phy_u.defer_crs <= 1'b1;
    phy_u.echo_crs <= 1'b1;
    load('{8'hC3, 8'h9E});
    repeat (400) @(posedge pclk);
    `CHECK("frames while busy", 1, phy_u.nframes)
    phy_u.defer_crs <= 1'b0;
    tx_end(3000);
    rdchk(12'h004, 32'h1F, 32'h0, "carrier seen");
    phy_u.col_at = 40;
    load('{8'h81, 8'h42, 8'h24, 8'h18, 8'hE7});
    wait_ev(3, 1'b1, 300);
    wait_ev(2, 1'b1, 3000);
    tx_end(6000);
    `CHECK("jam nibble", 4'h5, phy_u.prev_f[$])
    `CHECK("jam cut", 1'b1, phy_u.prev_f.size() < 56)
    rf = '{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    for (int i = 6; i < 60; i++) rf.push_back(8'h80 + 8'(i));
    to_nibs(rf, rn);
    phy_u.send(rn, -1);
    repeat (20) @(posedge pclk);
    rx_check(1, 1'b0);
    phy_u.send(rn, 50);
    repeat (20) @(posedge pclk);
    rx_check(2, 1'b1);
    rf[0] = 8'h06;
    to_nibs(rf, rn);
    phy_u.send(rn, -1);
    repeat (20) @(posedge pclk);
    `CHECK("filtered", 0, rq.size())
    rdchk(12'h004, 32'h1F, 32'h14, "rx status");
    apb(1'b1, 12'h000, 32'h2);
    phy_u.echo_crs <= 1'b0;
    rf[0] = 8'h02;
    to_nibs(rf, rn);
    fork
      phy_u.send(rn, -1);
    join_none
    repeat (100) @(posedge pclk);
    load('{8'h5A, 8'hA5, 8'h3C});
    wait_ev(3, 1'b1, 400);
    tx_end(3000);
    repeat (100) @(posedge pclk);
    rx_check(3, 1'b0);
    // Serial mode, one bit per line clock in bit 0, same wire order as the nibbles
    apb(1'b1, 12'h000, 32'h3);
    load('{8'h96, 8'h3C});
    wait_ev(1, 1'b1, 6000);
    wait_ev(3, 1'b0, 200);
    repeat (20) @(posedge pclk);
    `CHECK("tx bits", 4 * exp_n.size(), phy_u.last_f.size())
    foreach (exp_n[i])
      for (int j = 0; j < 4; j++)
        `CHECK("tx bit", {3'h0, exp_n[i][j]}, phy_u.last_f[4*i+j])
    print_verdict();
  end
endmodule

// file: verification/cmac_core_props.sv
`timescale 1ns/1ps

module cmac_core_props (
  // System and register bus
  input wire        pclk,
  input wire        presetn,
  input wire [11:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  // Transmit FIFO and receive side
  input wire        tx_pop,
  input wire        tx_done,
  input wire        tx_abort,
  input wire        tx_rewind,
  input wire        rx_valid,
  input wire        rx_last,
  // Line
  input wire        tx_line_clock,
  input wire [3:0]  txd,
  input wire        tx_en,
  input wire        col
);
  reg       tlc_q;
  reg [3:0] age;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Cycles since the raw line clock rose; saturates so idle stretches never wrap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tlc_q <= 1'b0;
      age   <= 4'hF;
    end else begin
      tlc_q <= tx_line_clock;
      age   <= (tx_line_clock && !tlc_q) ? 4'h0 : ((age == 4'hF) ? age : age + 4'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_col_hit;
    $rose(col) && tx_en;
  endsequence
  sequence s_line_quiet;
    !tx_en;
  endsequence

  pready_timing_a: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_decode_a: assert property (pready |->
                  (pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C})))
    else $error("pslverr does not match decode");
  line_edge_a: assert property (!$stable({tx_en, txd}) |-> age inside {[1:6]})
    else $error("txd or tx_en moved away from a line clock rise");
  jam_stop_a: assert property (s_col_hit |-> ##[1:160] s_line_quiet)
    else $error("transmission not cut short after collision");
  done_clean_a: assert property (tx_done |-> !tx_rewind && !tx_abort)
    else $error("done together with rewind or abort");
  pop_gap_a: assert property (tx_pop |=> !tx_pop [*4])
    else $error("byte pops too close together");
  rx_tail_a: assert property (rx_valid && rx_last |=> !rx_valid [*8])
    else $error("bytes after final byte");
  rx_last_valid_a: assert property (rx_last |-> rx_valid)
    else $error("rx_last without rx_valid");
endmodule

bind cmac_core cmac_core_props props_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .tx_pop(tx_pop), .tx_done(tx_done),
  .tx_abort(tx_abort), .tx_rewind(tx_rewind), .rx_valid(rx_valid), .rx_last(rx_last),
  .tx_line_clock(tx_line_clock), .txd(txd), .tx_en(tx_en), .col(col)
);

// file: verification/cmac_phy_model.sv
`timescale 1ns/1ps

module cmac_phy_model (
  // Line clocks
  output reg        tx_line_clock,
  output reg        rx_line_clock,
  // Transmit side
  input  wire [3:0] txd,
  input  wire       tx_en,
  output reg        col,
  output wire       crs,
  // Receive side
  output reg        rx_dv,
  output reg        rx_er,
  output reg  [3:0] rxd
);
  logic       rx_crs = 1'b0;
  logic       echo_crs = 1'b0;
  logic       defer_crs = 1'b0;
  int         col_at = 0;
  int         nframes = 0;
  logic [3:0] cur[$];
  logic [3:0] last_f[$];
  logic [3:0] prev_f[$];

  assign crs = rx_crs | defer_crs | (echo_crs & tx_en);

  initial begin
    tx_line_clock = 1'b0;
    rx_line_clock = 1'b0;
    col = 1'b0;
    rx_dv = 1'b0;
    rx_er = 1'b0;
    rxd = 4'hA;
  end

  // Free-running clocks at 10 Mbps MII rate, phases unrelated to each other
  always #200 tx_line_clock = ~tx_line_clock;
  initial begin
    #137;
    forever #200 rx_line_clock = ~rx_line_clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Capture nibbles; one collision burst of three clocks, then it disarms itself
  always @(posedge tx_line_clock) begin
    if (tx_en) begin
      cur.push_back(txd);
    end else if (cur.size() != 0) begin
      prev_f = last_f;
      last_f = cur;
      cur = {};
      nframes++;
    end
    col <= col_at != 0 && tx_en && cur.size() >= col_at && cur.size() < col_at + 3;
    if (cur.size() == col_at + 3) begin
      col_at = 0;
    end
  end

  // Data changes on the falling edge so the MAC sees it settled at the rise
  task automatic send(input logic [3:0] n[$], input int er_at);
    @(negedge rx_line_clock) rx_crs <= 1'b1;
    repeat (4) @(negedge rx_line_clock);
    foreach (n[i]) begin
      @(negedge rx_line_clock);
      rx_dv <= 1'b1;
      rxd <= n[i];
      rx_er <= (i == er_at);
    end
    @(negedge rx_line_clock);
    rx_dv <= 1'b0;
    rx_er <= 1'b0;
    rxd <= ~n[n.size()-1];
    @(negedge rx_line_clock) rx_crs <= 1'b0;
  endtask
endmodule
